/* i2c_hs_slave.sv */
/*
 * two-wire slave: bus conditions, acknowledge, speed mode, resets.
 * assumes scl and sda pins arrive asynchronously and an external pad
 * resolves sda from sda_oe; supply_low comes from an analog comparator.
 */
`timescale 1ns/10ps
`include "i2c_hs_cfg.svh"
module i2c_hs_slave
#(
    parameter int POR_ARM_CYCLES = `POR_ARM_MS * `CLK_MHZ * 1000,
    parameter int POR_W          = 25
)
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        sda_out,
    output logic                        sda_oe,
    input  wire logic                   supply_low,
    input  wire logic [2:0]             addr_pins,
    input  wire logic [7:0]             tx_data,
    output logic                        tx_load,
    output logic [7:0]                  rx_data,
    output logic                        rx_valid,
    output logic                        hs_mode,
    output logic                        settings_reset,
    output i2c_hs_pkg::bus_state_t      bus_state
);
    import i2c_hs_pkg::*;

    localparam logic [`FILT_W-1:0] FS_CYC =
        `FILT_W'((`FILT_FS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
    localparam logic [`FILT_W-1:0] HS_CYC =
        `FILT_W'((`FILT_HS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
    localparam logic [POR_W-1:0] POR_MAX = POR_W'(POR_ARM_CYCLES);

    logic             scl_f;
    logic             sda_f;
    logic             sup_f;
    logic             scl_p;
    logic             sda_p;
    logic [3:0]       bit_cnt;
    logic [7:0]       shreg;
    logic             first;
    logic             rw;
    logic             gc;
    logic             to_idle;
    logic [2:0]       addr_lat;
    logic             latched;
    logic [POR_W-1:0] por_cnt;
    bus_state_t       state;

    // =====================================================================
    // input conditioning; scl and sda filter length follows the speed mode
    wire [`FILT_W-1:0] filt_len = hs_mode ? HS_CYC : FS_CYC;
    line_cond u_scl (.sys_clk(sys_clk), .rst_n(rst_n), .pin(scl_in),
                     .len(filt_len), .level(scl_f));
    line_cond u_sda (.sys_clk(sys_clk), .rst_n(rst_n), .pin(sda_in),
                     .len(filt_len), .level(sda_f));
    line_cond u_sup (.sys_clk(sys_clk), .rst_n(rst_n), .pin(supply_low),
                     .len(`FILT_W'(1)), .level(sup_f));

    // =====================================================================
    // bus condition decode
    wire start     = scl_f & scl_p & sda_p & ~sda_f;
    wire stop      = scl_f & scl_p & ~sda_p & sda_f;
    wire scl_rise  = scl_f & ~scl_p;
    wire scl_fall  = ~scl_f & scl_p;
    wire byte_done = (state == ST_RX) & scl_fall & (bit_cnt == `BYTE_BITS);
    wire is_mcode  = (shreg[7:3] == `MCODE_TOP);
    wire my_addr   = (shreg[7:1] == {`ADDR_BASE, addr_lat});
    wire is_gcall  = (shreg == `GENCALL_ADDR);
    wire gc_reset  = byte_done & ~first & gc & (shreg == `GC_RESET_CMD);
    wire gc_latch  = byte_done & ~first & gc & (shreg == `GC_LATCH_CMD);
    wire por_armed = (por_cnt == POR_MAX);
    wire por_fire  = por_armed & ~sup_f;
    wire mack_nack = (state == ST_MACK) & scl_rise & sda_f;

    // =====================================================================
    // line history for edge finding
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    // =====================================================================
    // power-on arm: a dip only counts once it lasts the full window,
    // so brief brown-outs leave settings alone
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            por_cnt <= '0;
        else if (!sup_f)
            por_cnt <= '0;
        else if (!por_armed)
            por_cnt <= por_cnt + 1'b1;
    end

    // =====================================================================
    // address pin latch: at first START, on power-on, or on a general call reset or latch command
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_lat <= 3'h0;
            latched  <= 1'b0;
        end
        else if (por_fire || gc_reset || gc_latch || (start && !latched))
        begin
            addr_lat <= addr_pins;
            latched  <= 1'b1;
        end
    end

    // =====================================================================
    // main bus sequencer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state          <= ST_IDLE;
            bit_cnt        <= 4'h0;
            shreg          <= 8'h00;
            first          <= 1'b0;
            rw             <= 1'b0;
            gc             <= 1'b0;
            to_idle        <= 1'b0;
            hs_mode        <= 1'b0;
            sda_oe         <= 1'b0;
            rx_data        <= 8'h00;
            rx_valid       <= 1'b0;
            tx_load        <= 1'b0;
            settings_reset <= 1'b0;
        end
        else
        begin
            rx_valid       <= 1'b0;
            tx_load        <= 1'b0;
            settings_reset <= por_fire | gc_reset;
            if (por_fire)
            begin
                state   <= ST_IDLE;
                hs_mode <= 1'b0;
                sda_oe  <= 1'b0;
                to_idle <= 1'b0;
            end
            else if (stop)
            begin
                state   <= ST_IDLE;
                hs_mode <= 1'b0;
                sda_oe  <= 1'b0;
                to_idle <= 1'b0;
            end
            else if (start)
            begin
                state   <= ST_RX;
                bit_cnt <= 4'h0;
                first   <= 1'b1;
                gc      <= 1'b0;
                rw      <= 1'b0;
                sda_oe  <= 1'b0;
                to_idle <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_RX:
                    begin
                        if (scl_rise)
                        begin
                            shreg   <= {shreg[6:0], sda_f};
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                        if (byte_done)
                        begin
                            first <= 1'b0;
                            if (first && is_mcode)
                            begin
                                hs_mode <= 1'b1;
                                state   <= ST_IGNORE;
                            end
                            else if (first && my_addr)
                            begin
                                rw     <= shreg[0];
                                sda_oe <= 1'b1;
                                state  <= ST_ACK;
                            end
                            else if (first && is_gcall)
                            begin
                                gc     <= 1'b1;
                                sda_oe <= 1'b1;
                                state  <= ST_ACK;
                            end
                            else if (first)
                                state <= ST_IGNORE;
                            else
                            begin
                                rx_data  <= shreg;
                                rx_valid <= ~gc;
                                sda_oe   <= 1'b1;
                                to_idle  <= gc_reset;
                                state    <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK, ST_MACK:
                    begin
                        if (state == ST_MACK && scl_rise && sda_f)
                        begin
                            state <= ST_IGNORE;
                        end
                        else if (scl_fall && to_idle)
                        begin
                            sda_oe  <= 1'b0;
                            hs_mode <= 1'b0;
                            to_idle <= 1'b0;
                            state   <= ST_IDLE;
                        end
                        else if (scl_fall && rw)
                        begin
                            shreg   <= tx_data;
                            sda_oe  <= ~tx_data[7];
                            bit_cnt <= 4'h1;
                            tx_load <= 1'b1;
                            state   <= ST_TX;
                        end
                        else if (scl_fall)
                        begin
                            sda_oe  <= 1'b0;
                            bit_cnt <= 4'h0;
                            state   <= ST_RX;
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall && bit_cnt == `BYTE_BITS)
                        begin
                            sda_oe <= 1'b0;              // master acknowledges now
                            state  <= ST_MACK;
                        end
                        else if (scl_fall)
                        begin
                            shreg   <= {shreg[6:0], 1'b0};
                            sda_oe  <= ~shreg[6];
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                    ST_IGNORE, ST_IDLE:
                        sda_oe <= 1'b0;
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // =====================================================================
    // open-drain data only ever pulls low
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    assign bus_state = state;

    // =====================================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_mcode_taken;
        byte_done && first && is_mcode && !start && !stop && !por_fire;
    endsequence
    sequence s_read_nack;
        mack_nack && !start && !stop && !por_fire;
    endsequence

    property p_idle_quiet;
        (state == ST_IDLE) |-> !sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("data driven while idle");

    property p_start_rx;
        (start && !por_fire) |=> (state == ST_RX) && (bit_cnt == 4'h0) && !sda_oe;
    endproperty
    a_start_rx: assert property (p_start_rx) else $error("start not restarting byte");

    property p_stop_idle;
        (stop && !por_fire) |=> (state == ST_IDLE) && !hs_mode;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not ending transfer");

    property p_mcode;
        s_mcode_taken |=> hs_mode && !sda_oe ##1 !sda_oe;
    endproperty
    a_mcode: assert property (p_mcode) else $error("master code handled wrong");

    property p_hs_hold;
        (hs_mode && !stop && !por_fire && !(scl_fall && to_idle)) |=> hs_mode;
    endproperty
    a_hs_hold: assert property (p_hs_hold) else $error("high speed dropped early");

    property p_ack_low;
        (state == ST_ACK && !rw) |-> sda_oe;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("acknowledge not held");

    property p_nack_release;
        s_read_nack |=> !sda_oe && (state == ST_IGNORE);
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("data held after nack");

    property p_msb_first;
        tx_load |-> (sda_oe == !$past(tx_data[7]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

    property p_por;
        por_fire |=> settings_reset && !hs_mode && (state == ST_IDLE);
    endproperty
    a_por: assert property (p_por) else $error("power-on reset incomplete");

    property p_gc_reset;
        (gc_reset && !start && !stop && !por_fire) |=> settings_reset && (addr_lat == $past(addr_pins));
    endproperty
    a_gc_reset: assert property (p_gc_reset) else $error("general call reset missed");

endmodule // i2c_hs_slave

/* i2c_hs_cfg.svh */
/*
 * constants for the two-wire slave bus-condition and speed-mode block.
 * assumes a 200 MHz system clock; included by i2c_hs_slave and line_cond.
 */
`ifndef I2C_HS_CFG_SVH
`define I2C_HS_CFG_SVH

// =====================================================================
// timing
`define CLK_PERIOD_NS    5
`define CLK_MHZ          200
`define POR_ARM_MS       100
`define FILT_FS_NS       50
`define FILT_HS_NS       10

// =====================================================================
// byte codes and fields
`define ADDR_BASE        4'h9
`define GENCALL_ADDR     8'h00
`define GC_RESET_CMD     8'h06
`define GC_LATCH_CMD     8'h04
`define MCODE_TOP        5'h01
`define BYTE_BITS        4'h8
`define FILT_W           4

`endif

/* i2c_hs_pkg.sv */
/*
 * types for the two-wire slave block.
 * assumes i2c_hs_cfg.svh alongside.
 */
package i2c_hs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_ACK    = 3'b010,
        ST_TX     = 3'b011,
        ST_MACK   = 3'b100,
        ST_IGNORE = 3'b101
    } bus_state_t;
endpackage

/* line_cond.sv */
/*
 * input conditioner: two-flop synchroniser then spike filter.
 * assumes pin is asynchronous to clk; len is a stable filter length.
 */
`timescale 1ns/10ps
`include "i2c_hs_cfg.svh"
module line_cond
#(
    parameter int FW = `FILT_W
)
(
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire logic          pin,
    input  wire logic [FW-1:0] len,
    output logic               level
);
    logic          meta;
    logic          sync;
    logic [FW-1:0] cnt;
    wire           differs = (sync != level);
    wire           settled = (cnt >= len);

    // =====================================================================
    // synchroniser; meta feeds only sync
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 1'b1;
            sync <= 1'b1;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
        end
    end

    // =====================================================================
    // spike filter: new level must hold len+1 cycles, shorter pulses vanish
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt   <= '0;
            level <= 1'b1;
        end
        else if (!differs)
            cnt <= '0;
        else if (settled)
        begin
            level <= sync;
            cnt   <= '0;
        end
        else
            cnt <= cnt + 1'b1;
    end
endmodule // line_cond

/* i2c_master_model.sv */
/*
 * bus master model: drives the clock line and pulls the data line.
 * assumes the bench resolves sda_line with a pull-up from both pullers.
 */
`timescale 1ns/10ps
module i2c_master_model
(
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_line
);
    // =====================================================================
    // bus timing
    real q = 200.0; // half clock period in ns, 64 in high-speed

    // idle: both lines released, clock stands still
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // =====================================================================
    // bit level
    // data moves mid-low so it never changes while the clock is high
    task automatic bit_cell(input logic b, output logic s);
        sda_low = ~b;
        #(q/2) scl = 1'b1;
        #(q/2) s = sda_line;
        #(q/2) scl = 1'b0;
        #(q/2);
    endtask

    // start or repeated start: data falls while clock high
    task automatic start();
        sda_low = 1'b0;
        #(q/2) scl = 1'b1;
        #q sda_low = 1'b1;
        #q scl = 1'b0;
        #(q/2);
    endtask

    // stop: data rises while clock high, then the clock stands
    task automatic stop();
        sda_low = 1'b1;
        #(q/2) scl = 1'b1;
        #q sda_low = 1'b0;
        #(2*q);
    endtask

    // =====================================================================
    // byte level
    // msb first, ninth cell released for the receiver
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cell(d[i], s);
        bit_cell(1'b1, s);
        ack = ~s;
    endtask

    // master acks each read byte, nack on the last ends it
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cell(1'b1, d[i]);
        bit_cell(~ack, s);
    endtask
endmodule // i2c_master_model

/* tb_top.sv */
/*
 * self-checking bench for i2c_hs_slave driven by a bus master model.
 * assumes the package, the design and i2c_master_model compile first.
 */
`timescale 1ns/10ps
module tb_top;
    import i2c_hs_pkg::*;
    logic       sys_clk, rst_n, supply_low, sda_out, sda_oe, tx_load, rx_valid;
    logic       hs_mode, settings_reset, scl, sda_low, sda_line;
    logic [2:0] addr_pins;
    logic [7:0] tx_data, rx_data;
    bus_state_t bus_state;
    int         error_cnt = 0, check_count = 0, rx_cnt = 0, sr_cnt = 0, ld_cnt = 0;

    // open-drain data line with pull-up, both pullers seen by both
    assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

    i2c_hs_slave #(.POR_ARM_CYCLES(50)) i_i2c_hs_slave
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .supply_low(supply_low),
        .addr_pins(addr_pins), .tx_data(tx_data), .tx_load(tx_load),
        .rx_data(rx_data), .rx_valid(rx_valid), .hs_mode(hs_mode),
        .settings_reset(settings_reset), .bus_state(bus_state)
    );
    i2c_master_model i_i2c_master_model (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));

    // =====================================================================
    // clock, pulse counters, read data source
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // pulses last one cycle, so count them rather than poll
    always @(posedge sys_clk)
    begin
        rx_cnt <= rx_cnt + int'(rx_valid === 1'b1);
        sr_cnt <= sr_cnt + int'(settings_reset === 1'b1);
        ld_cnt <= ld_cnt + int'(tx_load === 1'b1);
    end
    always @(negedge sys_clk)
        tx_data <= ld_cnt[0] ? 8'h5a : 8'hc3;

    // =====================================================================
    // compares and verdict
    task automatic chk_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_state(input string n, input bus_state_t e, input bus_state_t g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // =====================================================================
    // scenarios
    task automatic t_write();
        logic       a;
        logic [7:0] wd [3] = '{8'h81, 8'h3c, 8'ha5};
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h9a, a);
        chk_bit("addr ack", 1'b1, a);
        for (int i = 0; i < 3; i++)
        begin
            i_i2c_master_model.wbyte(wd[i], a);
            chk_bit("data ack", 1'b1, a);
            chk_byte("rx_data", wd[i], rx_data);
        end
        i_i2c_master_model.stop();
        chk_byte("rx pulses", 8'h03, rx_cnt[7:0]);
        chk_state("state after stop", ST_IDLE, bus_state);
        chk_bit("idle release", 1'b0, sda_oe);
        chk_bit("open drain level", 1'b0, sda_out);
        $display("test write done");
    endtask

    task automatic t_read();
        logic       a;
        logic [7:0] d;
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h9b, a);
        chk_bit("read addr ack", 1'b1, a);
        i_i2c_master_model.rbyte(1'b1, d);
        chk_byte("read byte 0", 8'hc3, d);
        i_i2c_master_model.rbyte(1'b0, d);
        chk_byte("read byte 1", 8'h5a, d);
        chk_bit("release on nack", 1'b0, sda_oe);
        chk_byte("load pulses", 8'h02, ld_cnt[7:0]);
        i_i2c_master_model.stop();
        $display("test read done");
    endtask

    // master code never acked; high speed holds over repeated start
    task automatic t_hs();
        logic a;
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h0d, a);
        chk_bit("code ack", 1'b0, a);
        chk_bit("hs on", 1'b1, hs_mode);
        // low phase must outlast the slave's filter and response latency,
        // else its late release of the ack looks like a start or stop
        i_i2c_master_model.q = 64.0;
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h9a, a);
        chk_bit("hs addr ack", 1'b1, a);
        i_i2c_master_model.wbyte(8'h77, a);
        chk_byte("hs rx_data", 8'h77, rx_data);
        i_i2c_master_model.start();
        chk_bit("hs over restart", 1'b1, hs_mode);
        i_i2c_master_model.stop();
        chk_bit("fast after stop", 1'b0, hs_mode);
        i_i2c_master_model.q = 200.0;
        $display("test high speed done");
    endtask

    // latch command takes new pins; old address is then refused
    task automatic t_latch();
        logic a;
        @(negedge sys_clk);
        addr_pins = 3'b010;
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h00, a);
        i_i2c_master_model.wbyte(8'h04, a);
        chk_bit("latch ack", 1'b1, a);
        i_i2c_master_model.stop();
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h9a, a);
        chk_bit("old addr", 1'b0, a);
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h94, a);
        chk_bit("new addr", 1'b1, a);
        i_i2c_master_model.stop();
        $display("test latch done");
    endtask

    // reset command out of high-speed mode
    task automatic t_gc();
        logic a;
        int   n = sr_cnt;
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h0b, a);
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h00, a);
        chk_bit("gc ack", 1'b1, a);
        i_i2c_master_model.wbyte(8'h06, a);
        chk_bit("reset ack", 1'b1, a);
        chk_byte("reset pulses", 8'(n + 1), sr_cnt[7:0]);
        chk_bit("fast after reset", 1'b0, hs_mode);
        chk_state("state after reset", ST_IDLE, bus_state);
        i_i2c_master_model.stop();
        $display("test general reset done");
    endtask

    // partial bytes are dropped by restart and by stop
    task automatic t_abort();
        logic a, s;
        int   n = rx_cnt;
        i_i2c_master_model.start();
        repeat (3) i_i2c_master_model.bit_cell(1'b1, s);
        i_i2c_master_model.start();
        i_i2c_master_model.wbyte(8'h94, a);
        chk_bit("ack after restart", 1'b1, a);
        repeat (4) i_i2c_master_model.bit_cell(1'b0, s);
        i_i2c_master_model.stop();
        chk_state("state after abort", ST_IDLE, bus_state);
        chk_byte("no partial byte", 8'(n), rx_cnt[7:0]);
        $display("test abort done");
    endtask

    // short dip must not arm; a long one fires one reset
    task automatic t_por();
        int n = sr_cnt;
        @(negedge sys_clk);
        supply_low = 1'b1;
        repeat (30) @(negedge sys_clk);
        supply_low = 1'b0;
        repeat (20) @(negedge sys_clk);
        chk_byte("short dip", 8'(n), sr_cnt[7:0]);
        supply_low = 1'b1;
        repeat (60) @(negedge sys_clk);
        supply_low = 1'b0;
        for (int i = 0; i < 20 && sr_cnt == n; i++)
            @(negedge sys_clk);
        chk_byte("power-on pulse", 8'(n + 1), sr_cnt[7:0]);
        chk_state("state after power-on", ST_IDLE, bus_state);
        $display("test power-on done");
    endtask

    // =====================================================================
    // main sequence and hang guard
    initial
    begin
        rst_n = 1'b0;
        supply_low = 1'b0;
        addr_pins = 3'b101;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk_bit("hs after reset", 1'b0, hs_mode);
        chk_state("state after reset", ST_IDLE, bus_state);
        t_write();
        t_read();
        t_hs();
        t_latch();
        t_gc();
        t_abort();
        t_por();
        results();
    end
    initial
    begin
        #400000;
        error_cnt++;
        results();
    end
endmodule // tb_top
